// ### design/edge_sync_detect.sv
`include "timer_regs.svh"

module edge_sync_detect (
  input wire logic clk_sys,      // System clock
  input wire logic reset,        // Synchronous reset, active high
  input wire logic pin_in,       // Asynchronous pin level
  input wire logic [1:0] edge_sel, // Edge selection code
  input wire logic enable,       // Detection allowed
  output logic edge_pulse        // One-cycle pulse on a selected edge
);

  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;
  logic level_reg;
  logic settled;
  logic rise;
  logic fall;

  // Three-stage synchroniser; the first stage feeds only the second
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Accepted level moves only once the last two stages agree
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      level_reg <= 1'b0;
    else if (settled)
      level_reg <= sync3_reg;
  end

  // Edge decode: a change counts when stages two and three agree on it
  assign settled = (sync2_reg == sync3_reg);
  assign rise = settled & sync3_reg & ~level_reg;
  assign fall = settled & ~sync3_reg & level_reg;

  always_comb
  begin
    case (edge_sel)
      `EDGE_RISE: edge_pulse = enable & rise;
      `EDGE_FALL: edge_pulse = enable & fall;
      `EDGE_BOTH: edge_pulse = enable & (rise | fall);
      default: edge_pulse = 1'b0;
    endcase
  end

endmodule

// ### design/timer_unit_b.sv
// The placing of the registers and the APB slave port are this design's own decisions.
`include "timer_regs.svh"

module timer_unit_b (
  input wire logic clk_sys,            // 200 MHz system clock
  input wire logic reset,              // Synchronous reset, active high
  input wire logic psel,               // APB select
  input wire logic penable,            // APB enable
  input wire logic pwrite,             // APB write direction
  input wire logic [7:0] paddr,        // APB byte address
  input wire logic [31:0] pwdata,      // APB write data
  output logic [31:0] prdata,          // APB read data
  output logic pready,                 // APB ready
  output logic pslverr,                // APB error for unmapped address
  input wire logic event_in,           // External event count input pin
  input wire logic trigger_in,         // External trigger input pin
  input wire logic [3:0] capture_in,   // Capture trigger input pins
  output logic [1:0] timer_output_pin  // Timer output pins
);

  timer_pkg::first_ctl_s first_ctl_reg;
  timer_pkg::second_ctl_s second_ctl_reg;
  timer_pkg::output_ctl_s output_ctl_reg;
  logic [7:0] capture_edge_reg;
  timer_pkg::event_edge_s event_edge_reg;
  timer_pkg::count_t period_reg;
  timer_pkg::count_t counter_reg;
  timer_pkg::count_t counter_next;
  timer_pkg::count_t capture_reg [`CAPTURE_CHANNELS];
  logic [7:0] prescale_reg;
  logic pulse_active_reg;
  logic wave_reg;
  logic [1:0] pin_next;
  logic pready_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic access_wait;
  logic write_commit;
  logic [31:0] read_value;
  logic read_mapped;
  logic ext_clock_sel;
  logic internal_tick;
  logic event_pulse;
  logic trigger_pulse;
  logic [3:0] capture_pulse;
  logic count_tick;
  logic trig_mode;
  logic capture_mode;
  logic sw_trigger;
  logic start_pulse;
  logic at_period;
  logic count_allowed;

  // True when the APB address selects the given register offset
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
    addr_hit = (addr == ofs);
  endfunction

  // Prescaler mask: divide by two to the power of the clock select
  function automatic logic [7:0] prescale_mask(input logic [2:0] sel);
    prescale_mask = 8'((9'h001 << sel) - 9'h001);
  endfunction

  // APB handshake: one wait state, data and error loaded on the same edge as ready
  assign access_wait = psel & penable & ~pready_reg;
  assign write_commit = psel & penable & pready_reg & pwrite;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      pready_reg <= 1'b0;
    else
      pready_reg <= access_wait;
  end

  // Read multiplexer; reserved bits read as zero
  always_comb
  begin
    read_value = 32'h0000_0000;
    read_mapped = 1'b1;
    if (addr_hit(paddr, `OFS_FIRST_CTL))
    begin
      read_value[`BIT_RUN] = first_ctl_reg.run;
      read_value[`BIT_CKS_HI:`BIT_CKS_LO] = first_ctl_reg.clock_select;
    end
    else if (addr_hit(paddr, `OFS_SECOND_CTL))
    begin
      read_value[`BIT_EVENT_CLK_EN] = second_ctl_reg.event_clk_en;
      read_value[`BIT_MODE_HI:`BIT_MODE_LO] = second_ctl_reg.mode;
    end
    else if (addr_hit(paddr, `OFS_OUTPUT_CTL))
      read_value[3:0] = output_ctl_reg;
    else if (addr_hit(paddr, `OFS_CAPTURE_EDGE))
      read_value[7:0] = capture_edge_reg;
    else if (addr_hit(paddr, `OFS_EVENT_EDGE))
      read_value[3:0] = event_edge_reg;
    else if (addr_hit(paddr, `OFS_PERIOD))
      read_value[15:0] = period_reg;
    else if (addr_hit(paddr, `OFS_COUNTER))
      read_value[15:0] = counter_reg;
    else if (addr_hit(paddr, `OFS_CAPTURE0))
      read_value[15:0] = capture_reg[0];
    else if (addr_hit(paddr, `OFS_CAPTURE1))
      read_value[15:0] = capture_reg[1];
    else if (addr_hit(paddr, `OFS_CAPTURE2))
      read_value[15:0] = capture_reg[2];
    else if (addr_hit(paddr, `OFS_CAPTURE3))
      read_value[15:0] = capture_reg[3];
    else
      read_mapped = 1'b0;
  end

  // Response data and error held through the ready cycle
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else if (access_wait)
    begin
      prdata_reg <= pwrite ? 32'h0000_0000 : read_value;
      pslverr_reg <= ~read_mapped;
    end
    else if (!pready_reg)
    begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // Control register writes; software keeps the stop-before-change
  // discipline, so writes are taken as given
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      first_ctl_reg <= '0;
      second_ctl_reg <= '0;
      output_ctl_reg <= '0;
      capture_edge_reg <= 8'h00;
      event_edge_reg <= '0;
      period_reg <= `PERIOD_RESET;
    end
    else if (write_commit)
    begin
      // Reserved positions are not stored and read back zero
      if (addr_hit(paddr, `OFS_FIRST_CTL))
        first_ctl_reg <= {pwdata[`BIT_RUN], pwdata[`BIT_CKS_HI:`BIT_CKS_LO]};
      if (addr_hit(paddr, `OFS_SECOND_CTL))
        second_ctl_reg <= {pwdata[`BIT_EVENT_CLK_EN], pwdata[`BIT_MODE_HI:`BIT_MODE_LO]};
      if (addr_hit(paddr, `OFS_OUTPUT_CTL))
        output_ctl_reg <= pwdata[3:0];
      if (addr_hit(paddr, `OFS_CAPTURE_EDGE))
        capture_edge_reg <= pwdata[7:0];
      if (addr_hit(paddr, `OFS_EVENT_EDGE))
        event_edge_reg <= pwdata[3:0];
      if (addr_hit(paddr, `OFS_PERIOD))
        period_reg <= pwdata[15:0];
    end
  end

  // Mode decode
  assign ext_clock_sel = second_ctl_reg.event_clk_en
    | (second_ctl_reg.mode == `MODE_EVENT_COUNT);
  assign trig_mode = (second_ctl_reg.mode == `MODE_EXT_TRIGGER)
    | (second_ctl_reg.mode == `MODE_ONE_SHOT);
  assign capture_mode = first_ctl_reg.run & ((second_ctl_reg.mode == `MODE_FREE_RUN)
    | (second_ctl_reg.mode == `MODE_PULSE_MEASURE));

  // Input pins: event edge only when event clock chosen, trigger only in trigger modes
  edge_sync_detect u_event_edge (
    .clk_sys(clk_sys),
    .reset(reset),
    .pin_in(event_in),
    .edge_sel(event_edge_reg.event_edge),
    .enable(ext_clock_sel),
    .edge_pulse(event_pulse)
  );

  edge_sync_detect u_trigger_edge (
    .clk_sys(clk_sys),
    .reset(reset),
    .pin_in(trigger_in),
    .edge_sel(event_edge_reg.trigger_edge),
    .enable(trig_mode),
    .edge_pulse(trigger_pulse)
  );

  // One capture detector per channel, two select bits each
  generate
    for (genvar ch = 0; ch < `CAPTURE_CHANNELS; ch++)
    begin : g_capture
      edge_sync_detect u_capture_edge (
        .clk_sys(clk_sys),
        .reset(reset),
        .pin_in(capture_in[ch]),
        .edge_sel(capture_edge_reg[2*ch+1:2*ch]),
        .enable(capture_mode),
        .edge_pulse(capture_pulse[ch])
      );
    end
  endgenerate

  // Internal prescaler, cleared while stopped so the first tick is predictable
  always_ff @(posedge clk_sys)
  begin
    if (reset || !first_ctl_reg.run)
      prescale_reg <= 8'h00;
    else
      prescale_reg <= prescale_reg + `PRESCALE_ONE;
  end

  assign internal_tick = (prescale_reg & prescale_mask(first_ctl_reg.clock_select))
    == prescale_mask(first_ctl_reg.clock_select);
  assign count_tick = ext_clock_sel ? event_pulse : internal_tick;

  // Software trigger is a write of one in a trigger mode while running
  assign sw_trigger = write_commit & addr_hit(paddr, `OFS_SECOND_CTL) & pwdata[`BIT_SW_TRIGGER]
    & trig_mode & first_ctl_reg.run;
  assign start_pulse = first_ctl_reg.run & (sw_trigger | trigger_pulse);
  assign at_period = (counter_reg == period_reg);
  assign count_allowed = first_ctl_reg.run & count_tick & (!trig_mode | pulse_active_reg);

  // Pulse window for trigger and one-shot modes
  always_ff @(posedge clk_sys)
  begin
    if (reset || !first_ctl_reg.run)
      pulse_active_reg <= 1'b0;
    else if (start_pulse)
      pulse_active_reg <= 1'b1;
    else if (trig_mode && count_allowed && at_period)
      pulse_active_reg <= 1'b0;
  end

  // Counter next value
  always_comb
  begin
    counter_next = counter_reg;
    if (!first_ctl_reg.run)
      counter_next = `COUNTER_ZERO;
    else if (start_pulse)
      counter_next = `COUNTER_ZERO;
    else if (capture_pulse[0] && second_ctl_reg.mode == `MODE_PULSE_MEASURE)
      counter_next = `COUNTER_ZERO;
    else if (count_allowed)
    begin
      if (at_period && second_ctl_reg.mode != `MODE_FREE_RUN)
        counter_next = `COUNTER_ZERO;
      else
        counter_next = counter_reg + `COUNTER_ONE;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      counter_reg <= `COUNTER_ZERO;
    else
      counter_reg <= counter_next;
  end

  // Capture latches, only reachable in the capture modes
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      for (int i = 0; i < `CAPTURE_CHANNELS; i++)
        capture_reg[i] <= `COUNTER_ZERO;
    end
    else
    begin
      for (int i = 0; i < `CAPTURE_CHANNELS; i++)
        if (capture_pulse[i])
          capture_reg[i] <= counter_reg;
    end
  end

  // Output waveform: toggles at the period, or follows the pulse window
  always_ff @(posedge clk_sys)
  begin
    if (reset || !first_ctl_reg.run)
      wave_reg <= 1'b0;
    else if (!trig_mode && count_allowed && at_period)
      wave_reg <= ~wave_reg;
  end

  // Pin level is the output level, inverted by the wave only when enabled
  always_comb
  begin
    for (int i = 0; i < 2; i++)
      pin_next[i] = output_ctl_reg.level[i] ^ (output_ctl_reg.enable[i]
        & (trig_mode ? pulse_active_reg : wave_reg));
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      timer_output_pin <= 2'h0;
    else
      timer_output_pin <= pin_next;
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  a_trigger_ignored: assert property (write_commit && addr_hit(paddr, `OFS_SECOND_CTL)
    && pwdata[`BIT_SW_TRIGGER] && !trig_mode && !pulse_active_reg |=> !pulse_active_reg)
    else $error("software trigger took effect outside trigger modes");
  a_event_clock_used: assert property (first_ctl_reg.run && $stable(first_ctl_reg.run)
    && second_ctl_reg.mode == `MODE_EVENT_COUNT && !event_pulse
    |=> counter_reg == $past(counter_reg))
    else $error("event count mode advanced without an event edge");
  a_output_level_idle: assert property (!first_ctl_reg.run && output_ctl_reg.enable == 2'h0
    |=> timer_output_pin == $past(output_ctl_reg.level))
    else $error("output pin does not follow level bits while idle");
  a_capture_mode_gate: assert property (!capture_mode
    |=> capture_reg[0] == $past(capture_reg[0]) && capture_reg[1] == $past(capture_reg[1]))
    else $error("capture occurred outside capture modes");
  a_one_shot_end: assert property (second_ctl_reg.mode == `MODE_ONE_SHOT && pulse_active_reg
    && count_allowed && at_period && !start_pulse
    |=> !pulse_active_reg ##1 (!pulse_active_reg || $past(start_pulse)))
    else $error("one-shot pulse did not end at the period");
  a_event_edge_gate: assert property (!ext_clock_sel |-> !event_pulse)
    else $error("event edge detected while event clock not selected");
  a_counter_stop_clear: assert property (!first_ctl_reg.run |=> counter_reg == `COUNTER_ZERO)
    else $error("counter not cleared after stop");
  a_counter_advance: assert property (count_allowed && !at_period && !start_pulse
    && !(capture_pulse[0] && second_ctl_reg.mode == `MODE_PULSE_MEASURE)
    |=> counter_reg == $past(counter_reg) + `COUNTER_ONE)
    else $error("counter did not advance on a count tick");

  c_one_shot_done: cover property (second_ctl_reg.mode == `MODE_ONE_SHOT && $fell(pulse_active_reg));
  c_capture_taken: cover property (capture_pulse[0] && capture_mode);
  c_event_counted: cover property (second_ctl_reg.mode == `MODE_EVENT_COUNT && event_pulse);
  c_wave_toggle: cover property ($rose(wave_reg) && output_ctl_reg.enable[0]);

endmodule

// ### inc/timer_pkg.sv
package timer_pkg;

  // First control register contents
  typedef struct packed {
    logic run;
    logic [2:0] clock_select;
  } first_ctl_s;

  // Second control register contents
  typedef struct packed {
    logic event_clk_en;
    logic [2:0] mode;
  } second_ctl_s;

  // Output control: level and enable per output
  typedef struct packed {
    logic [1:0] level;
    logic [1:0] enable;
  } output_ctl_s;

  // Event and trigger edge selection
  typedef struct packed {
    logic [1:0] trigger_edge;
    logic [1:0] event_edge;
  } event_edge_s;

  typedef logic [15:0] count_t;

endpackage

// ### inc/timer_regs.svh
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

// Register byte offsets
`define OFS_FIRST_CTL 8'h00
`define OFS_SECOND_CTL 8'h04
`define OFS_OUTPUT_CTL 8'h08
`define OFS_CAPTURE_EDGE 8'h0C
`define OFS_EVENT_EDGE 8'h10
`define OFS_PERIOD 8'h14
`define OFS_COUNTER 8'h18
`define OFS_CAPTURE0 8'h1C
`define OFS_CAPTURE1 8'h20
`define OFS_CAPTURE2 8'h24
`define OFS_CAPTURE3 8'h28

// Field positions in first_control_reg
`define BIT_RUN 7
`define BIT_CKS_LO 0
`define BIT_CKS_HI 2

// Field positions in second_control_reg
`define BIT_SW_TRIGGER 6
`define BIT_EVENT_CLK_EN 5
`define BIT_MODE_LO 0
`define BIT_MODE_HI 2

// Operating mode codes
`define MODE_INTERVAL 3'h0
`define MODE_EVENT_COUNT 3'h1
`define MODE_EXT_TRIGGER 3'h2
`define MODE_ONE_SHOT 3'h3
`define MODE_PWM 3'h4
`define MODE_FREE_RUN 3'h5
`define MODE_PULSE_MEASURE 3'h6

// Edge select codes
`define EDGE_NONE 2'h0
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3

// Reset values and counts
`define PERIOD_RESET 16'hFFFF
`define COUNTER_ZERO 16'h0000
`define COUNTER_ONE 16'h0001
`define PRESCALE_ONE 8'h01
`define CAPTURE_CHANNELS 4

`endif

// ### testbench/pin_driver.sv
// Far-side model of the event, trigger and capture pins
module pin_driver (
  input wire logic clk_sys,      // System clock
  output logic event_in,         // External event count pin
  output logic trigger_in,       // External trigger pin
  output logic [3:0] capture_in  // Capture trigger pins
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [5:0] pins = 6'h00;

  // Pins idle low between pulses
  assign event_in = pins[0];
  assign trigger_in = pins[1];
  assign capture_in = pins[5:2];

  // Pulse one pin n times; width sets a prompt or slow partner
  task automatic pulse(input int idx, input int n, input int width);
    repeat (n)
    begin
      @(posedge clk_sys);
      pins[idx] <= 1'b1;
      repeat (width) @(posedge clk_sys);
      pins[idx] <= 1'b0;
      repeat (width) @(posedge clk_sys);
    end
  endtask
endmodule

// ### testbench/testbench.sv
// Self-checking bench for the timer unit
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic event_in;
  logic trigger_in;
  logic [3:0] capture_in;
  logic [1:0] timer_output_pin;
  int err_total = 0;
  int num_checks = 0;
  logic [31:0] q;
  logic [31:0] c1;
  logic e;

  always #2.5 clk_sys = ~clk_sys;

  timer_unit_b u_timer_unit_b (
    .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_in(event_in), .trigger_in(trigger_in), .capture_in(capture_in),
    .timer_output_pin(timer_output_pin)
  );

  pin_driver u_pin_driver (
    .clk_sys(clk_sys), .event_in(event_in), .trigger_in(trigger_in), .capture_in(capture_in)
  );

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (err_total == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One APB transfer: setup, access, wait for ready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic er);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
    end
    while (pready !== 1'b1);
    rq = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dq;
    logic de;
    apb(1'b1, a, d, dq, de);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] rq);
    logic de;
    apb(1'b0, a, 32'h00000000, rq, de);
  endtask

  // Stop, program mode, then restart with clock select 0
  task automatic restart(input logic [31:0] ctl2);
    wr(8'h00, 32'h00000000);
    wr(8'h04, ctl2);
    wr(8'h00, 32'h00000080);
  endtask

  // Watchdog
  initial
  begin
    repeat (30000) @(posedge clk_sys);
    err_total++;
    summarize();
  end

  initial
  begin
    logic [31:0] rst_exp [7];
    logic [31:0] ev_exp [4];
    rst_exp = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0000FFFF, 32'h0};
    ev_exp = '{32'h0, 32'h3, 32'h3, 32'h6};
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    // Reset values and unmapped access
    for (int i = 0; i < 7; i++)
    begin
      rd(8'(4 * i), q);
      check(q, rst_exp[i]);
    end
    apb(1'b0, 8'h2C, 32'h0, q, e);
    check({q[30:0], e}, 32'h00000001);
    check({30'h0, timer_output_pin}, 32'h0);
    // Output level drives pin while stopped and disabled
    wr(8'h08, 32'h0000000C);
    repeat (3) @(posedge clk_sys);
    check({30'h0, timer_output_pin}, 32'h00000003);
    wr(8'h08, 32'h00000004);
    repeat (3) @(posedge clk_sys);
    check({30'h0, timer_output_pin}, 32'h00000001);
    // Counter runs with clock select set in the starting write
    wr(8'h00, 32'h00000081);
    rd(8'h00, q);
    check(q, 32'h00000081);
    rd(8'h18, c1);
    rd(8'h18, q);
    check({31'h0, q > c1}, 32'h00000001);
    wr(8'h00, 32'h00000001);
    rd(8'h18, q);
    check(q, 32'h00000000);
    // Event count mode for every edge code, event clock enable 0
    for (int k = 0; k < 4; k++)
    begin
      wr(8'h00, 32'h00000000);
      wr(8'h10, 32'(k));
      restart(32'h00000001);
      u_pin_driver.pulse(0, 3, 2 + 4 * k);
      rd(8'h18, q);
      check(q, ev_exp[k]);
    end
    // Interval mode counting events through the enable bit
    wr(8'h00, 32'h00000000);
    wr(8'h10, 32'h00000001);
    restart(32'h00000020);
    u_pin_driver.pulse(0, 3, 3);
    rd(8'h18, q);
    check(q, 32'h00000003);
    // Trigger modes: idle until software trigger, pulse on output 0
    wr(8'h00, 32'h00000000);
    wr(8'h08, 32'h00000001);
    wr(8'h14, 32'h00000040);
    for (int m = 2; m < 4; m++)
    begin
      restart(32'(m));
      rd(8'h18, q);
      check(q, 32'h00000000);
      check({30'h0, timer_output_pin}, 32'h0);
      wr(8'h04, 32'(m) | 32'h00000040);
      rd(8'h18, q);
      check({31'h0, q != 32'h0}, 32'h00000001);
      check({31'h0, timer_output_pin[0]}, 32'h00000001);
      repeat (100) @(posedge clk_sys);
      check({31'h0, timer_output_pin[0]}, 32'h0);
    end
    // External trigger pin starts the pulse in trigger mode
    wr(8'h00, 32'h00000000);
    wr(8'h10, 32'h00000004);
    restart(32'h00000002);
    u_pin_driver.pulse(1, 1, 2);
    repeat (3) @(posedge clk_sys);
    check({31'h0, timer_output_pin[0]}, 32'h00000001);
    // Capture only in free-run and pulse measure modes; counter kept nonzero in every mode
    wr(8'h00, 32'h00000000);
    wr(8'h08, 32'h00000000);
    wr(8'h10, 32'h00000001);
    wr(8'h0C, 32'h00000001);
    for (int m = 0; m < 7; m++)
    begin
      restart(32'(m));
      wr(8'h04, 32'(m) | 32'h00000040);
      u_pin_driver.pulse(0, 2, 2);
      repeat (10 + m) @(posedge clk_sys);
      rd(8'h1C, c1);
      u_pin_driver.pulse(2, 1, 3);
      rd(8'h1C, q);
      check({31'h0, q != c1}, {31'h0, m >= 5});
    end
    // Interval mode toggles output 0 once every five ticks
    wr(8'h00, 32'h00000000);
    wr(8'h08, 32'h00000001);
    wr(8'h14, 32'h00000004);
    restart(32'h00000000);
    repeat (7) @(posedge clk_sys);
    e = timer_output_pin[0];
    repeat (5) @(posedge clk_sys);
    check({31'h0, timer_output_pin[0]}, {31'h0, ~e});
    wr(8'h00, 32'h00000000);
    summarize();
  end
endmodule
